//--- hdl/etvb_defines.vh
// register offsets, field positions, reset values and counts of the bank
`ifndef ETVB_DEFINES_VH
`define ETVB_DEFINES_VH

// register word addresses
`define ETVB_ADDR_ENGINE_CONFIG 12'h020
`define ETVB_ADDR_PULSE_RATE_SCALE 12'h021
`define ETVB_ADDR_HALF_CYCLE_COUNT 12'h083
`define ETVB_ADDR_TOTAL_REAL 12'h084
`define ETVB_ADDR_ELEM0_REAL 12'h085
`define ETVB_ADDR_ELEM1_REAL 12'h086
`define ETVB_ADDR_TOTAL_REACTIVE 12'h088
`define ETVB_ADDR_ELEM0_REACTIVE 12'h089
`define ETVB_ADDR_ELEM1_REACTIVE 12'h08A
`define ETVB_ADDR_ELEM0_ISQ 12'h08C
`define ETVB_ADDR_ELEM1_ISQ 12'h08D
`define ETVB_ADDR_ELEM0_VSQ 12'h090
`define ETVB_ADDR_ELEM1_VSQ 12'h091

// engine_config fields
`define ETVB_CFG_PULSE_SLOW 0
`define ETVB_CFG_PULSE_FAST 1

// reset values
`define ETVB_RST_ENGINE_CONFIG 32'h00000000
`define ETVB_RST_PULSE_RATE_SCALE 32'h00000100

// accumulation interval in samples
`define ETVB_ACC_COUNT 2520

// pulse generator: threshold exponent and speed shift
`define ETVB_PULSE_EXP 46
`define ETVB_SPEED_SHIFT 4

// metering equation codes that use both elements start here
`define ETVB_EQU_TWO_ELEM 3'h2

`endif

//--- hdl/etvb_satacc.v
// saturating per-interval accumulator with a held result register
`timescale 1ns/100ps
`default_nettype none

module etvb_satacc
#(
	parameter W = 32
)
(
	// clock and reset
	input wire clk,
	input wire nrst,
	// sample input
	input wire add,
	input wire last,
	input wire [W-1:0] val,
	// held result of the last interval
	output reg [W-1:0] result
);

reg [W-1:0] sum;
wire [W:0] raw;
reg [W-1:0] next_sum;

assign raw = {sum[W-1], sum} + {val[W-1], val};

// clamp to the extreme value instead of wrapping
always @*
begin
	if (raw[W] != raw[W-1])
		next_sum = raw[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
	else
		next_sum = raw[W-1:0];
end

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		sum <= {W{1'b0}};
		result <= {W{1'b0}};
	end
	else if (add)
	begin
		if (last)
		begin
			// result changes only here, once per interval
			result <= next_sum;
			sum <= {W{1'b0}};
		end
		else
			sum <= next_sum;
	end
end

endmodule // etvb_satacc

`default_nettype wire

//--- hdl/etvb_pulse.v
// energy pulse generator driven by a held per-interval energy result
`timescale 1ns/100ps
`default_nettype none
`include "etvb_defines.vh"

module etvb_pulse
(
	// clock and reset
	input wire clk,
	input wire nrst,
	// one step per sample
	input wire step,
	// rate scale, energy source and speed bits
	input wire [31:0] rate,
	input wire [31:0] energy,
	input wire [1:0] speed,
	// pulse output and sign of the source
	output reg pulse,
	output reg negative
);

localparam [69:0] THRESH = 70'd1 << `ETVB_PULSE_EXP;

wire [31:0] mag;
wire [63:0] prod;
reg [67:0] scaled;
wire [69:0] total;
wire [69:0] rest;
reg [69:0] acc;

assign mag = energy[31] ? (~energy + 32'h00000001) : energy;
assign prod = rate * mag;
assign total = acc + {2'h0, scaled};
assign rest = total - THRESH;

// speed factor: both bits clear keeps the base rate
always @*
begin
	case (speed)
		2'b10: scaled = {prod, 4'h0};
		2'b01: scaled = {8'h00, prod[63:`ETVB_SPEED_SHIFT]};
		default: scaled = {4'h0, prod};
	endcase
end

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		acc <= 70'h0;
		pulse <= 1'b0;
		negative <= 1'b0;
	end
	else
	begin
		pulse <= 1'b0;
		if (step)
		begin
			negative <= energy[31];
			if (total >= THRESH)
			begin
				pulse <= 1'b1;
				// at most one pulse per sample; the remainder rolls over, capped at THRESH
				acc <= (rest >= THRESH) ? THRESH : rest;
			end
			else
				acc <= total;
		end
	end
end

endmodule // etvb_pulse

`default_nettype wire

//--- hdl/etvb_top.v
// energy transfer variable bank: results, config and pulse generators
// Operation
// - accumulated results clamp at their extreme value, never wrap
// - totals are signed sums of element values per metering equation
// - each element's real energy of the last interval at its address
// - squared current and voltage sums of the last interval exposed
// - voltage half-cycle count of the last interval reported
// - two config bits pick pulse speed; both zero keep base rate
// - programmable rate scales pulses per unit energy
// - pulse generators fed by element 0 real and reactive energy
// - element 0 current square sum held at its address
// - results are 32-bit signed two's complement
// - interrupt on fresh results; results held for whole interval
// - interval length is a sample count, typically 2520
`timescale 1ns/100ps
`default_nettype none
`include "etvb_defines.vh"

module etvb_top
#(
	parameter ACC_COUNT = `ETVB_ACC_COUNT,
	parameter SAMPLE_W = 16
)
(
	// clock and reset
	input wire CLK,
	input wire NRST,
	// per-sample inputs from the compute engine
	input wire SAMPLE_STROBE,
	input wire [31:0] SAMPLE_W0,
	input wire [31:0] SAMPLE_W1,
	input wire [31:0] SAMPLE_VAR0,
	input wire [31:0] SAMPLE_VAR1,
	input wire [SAMPLE_W-1:0] SAMPLE_I0,
	input wire [SAMPLE_W-1:0] SAMPLE_I1,
	input wire [SAMPLE_W-1:0] SAMPLE_V0,
	input wire [SAMPLE_W-1:0] SAMPLE_V1,
	// metering equation select
	input wire [2:0] METER_EQU,
	// register port
	input wire [11:0] REG_ADDR,
	input wire REG_WR,
	input wire [31:0] REG_WDATA,
	input wire REG_RD,
	output reg [31:0] REG_RDATA,
	// fresh results event
	output reg RESULT_READY_INT,
	// pulse outputs
	output wire REAL_PULSE,
	output wire REAL_NEGATIVE,
	output wire REACTIVE_PULSE,
	output wire REACTIVE_NEGATIVE
);

localparam NCH = 8;
localparam [31:0] LAST_IDX = ACC_COUNT - 1;

reg [31:0] engine_config;
reg [31:0] pulse_rate_scale;
reg [31:0] sample_idx;
reg [31:0] edge_run;
reg [31:0] half_cycle_count;
reg stable_sign;
reg prev_sign;
reg next_sign;
reg [31:0] next_rdata;
reg [31:0] total_real_energy;
reg [31:0] total_reactive_energy;
wire last_sample;
wire edge_seen;
wire both_elem;
wire signed [31:0] sq_i0;
wire signed [31:0] sq_i1;
wire signed [31:0] sq_v0;
wire signed [31:0] sq_v1;
wire [NCH*32-1:0] ch_in;
wire [NCH*32-1:0] ch_out;
wire [32:0] raw_real;
wire [32:0] raw_reactive;

// interval boundary after ACC_COUNT samples
assign last_sample = SAMPLE_STROBE && (sample_idx == LAST_IDX);

always @(posedge CLK or negedge NRST)
begin
	if (!NRST)
		sample_idx <= 32'h00000000;
	else if (SAMPLE_STROBE)
		sample_idx <= last_sample ? 32'h00000000 : sample_idx + 32'h00000001;
end

// squares are formed as signed products, always non-negative
assign sq_i0 = $signed(SAMPLE_I0) * $signed(SAMPLE_I0);
assign sq_i1 = $signed(SAMPLE_I1) * $signed(SAMPLE_I1);
assign sq_v0 = $signed(SAMPLE_V0) * $signed(SAMPLE_V0);
assign sq_v1 = $signed(SAMPLE_V1) * $signed(SAMPLE_V1);

// channel order: W0 W1 VAR0 VAR1 I0sq I1sq V0sq V1sq
assign ch_in = {sq_v1, sq_v0, sq_i1, sq_i0,
	SAMPLE_VAR1, SAMPLE_VAR0, SAMPLE_W1, SAMPLE_W0};

genvar g;
generate
	for (g = 0; g < NCH; g = g + 1)
	begin : acc_ch
		etvb_satacc #(.W(32)) u_acc
		(
			.clk(CLK),
			.nrst(NRST),
			.add(SAMPLE_STROBE),
			.last(last_sample),
			.val(ch_in[g*32 +: 32]),
			.result(ch_out[g*32 +: 32])
		);
	end
endgenerate

// debounced sign change of the element 0 voltage counts a half-cycle
always @*
begin
	next_sign = SAMPLE_V0[SAMPLE_W-1];
end

assign edge_seen = SAMPLE_STROBE && (next_sign == prev_sign)
	&& (next_sign != stable_sign);

always @(posedge CLK or negedge NRST)
begin
	if (!NRST)
	begin
		prev_sign <= 1'b0;
		stable_sign <= 1'b0;
		edge_run <= 32'h00000000;
		half_cycle_count <= 32'h00000000;
	end
	else if (SAMPLE_STROBE)
	begin
		prev_sign <= next_sign;
		if (edge_seen)
			stable_sign <= next_sign;
		if (last_sample)
		begin
			half_cycle_count <= edge_run + {31'h0, edge_seen};
			edge_run <= 32'h00000000;
		end
		else
			edge_run <= edge_run + {31'h0, edge_seen};
	end
end

// totals: element 1 joins only for two-element equations
assign both_elem = (METER_EQU >= `ETVB_EQU_TWO_ELEM);
assign raw_real = {ch_out[31], ch_out[31:0]}
	+ (both_elem ? {ch_out[63], ch_out[63:32]} : 33'h0);
assign raw_reactive = {ch_out[95], ch_out[95:64]}
	+ (both_elem ? {ch_out[127], ch_out[127:96]} : 33'h0);

always @*
begin
	if (raw_real[32] != raw_real[31])
		total_real_energy = raw_real[32] ? 32'h80000000 : 32'h7FFFFFFF;
	else
		total_real_energy = raw_real[31:0];
	if (raw_reactive[32] != raw_reactive[31])
		total_reactive_energy = raw_reactive[32] ? 32'h80000000
			: 32'h7FFFFFFF;
	else
		total_reactive_energy = raw_reactive[31:0];
end

// fresh results event, raised on the same edge as the results update
always @(posedge CLK or negedge NRST)
begin
	if (!NRST)
		RESULT_READY_INT <= 1'b0;
	else
		RESULT_READY_INT <= last_sample;
end

// configuration registers
always @(posedge CLK or negedge NRST)
begin
	if (!NRST)
	begin
		engine_config <= `ETVB_RST_ENGINE_CONFIG;
		pulse_rate_scale <= `ETVB_RST_PULSE_RATE_SCALE;
	end
	else if (REG_WR)
	begin
		if (REG_ADDR == `ETVB_ADDR_ENGINE_CONFIG)
			engine_config <= REG_WDATA;
		if (REG_ADDR == `ETVB_ADDR_PULSE_RATE_SCALE)
			pulse_rate_scale <= REG_WDATA;
	end
end

// read mux: all results are 32-bit signed words
always @*
begin
	case (REG_ADDR)
		`ETVB_ADDR_ENGINE_CONFIG: next_rdata = engine_config;
		`ETVB_ADDR_PULSE_RATE_SCALE: next_rdata = pulse_rate_scale;
		`ETVB_ADDR_HALF_CYCLE_COUNT: next_rdata = half_cycle_count;
		`ETVB_ADDR_TOTAL_REAL: next_rdata = total_real_energy;
		`ETVB_ADDR_ELEM0_REAL: next_rdata = ch_out[31:0];
		`ETVB_ADDR_ELEM1_REAL: next_rdata = ch_out[63:32];
		`ETVB_ADDR_TOTAL_REACTIVE: next_rdata = total_reactive_energy;
		`ETVB_ADDR_ELEM0_REACTIVE: next_rdata = ch_out[95:64];
		`ETVB_ADDR_ELEM1_REACTIVE: next_rdata = ch_out[127:96];
		`ETVB_ADDR_ELEM0_ISQ: next_rdata = ch_out[159:128];
		`ETVB_ADDR_ELEM1_ISQ: next_rdata = ch_out[191:160];
		`ETVB_ADDR_ELEM0_VSQ: next_rdata = ch_out[223:192];
		`ETVB_ADDR_ELEM1_VSQ: next_rdata = ch_out[255:224];
		default: next_rdata = 32'h00000000;
	endcase
end

always @(posedge CLK or negedge NRST)
begin
	if (!NRST)
		REG_RDATA <= 32'h00000000;
	else if (REG_RD)
		REG_RDATA <= next_rdata;
end

// pulse generators on element 0 results
etvb_pulse u_real_pulse
(
	.clk(CLK),
	.nrst(NRST),
	.step(SAMPLE_STROBE),
	.rate(pulse_rate_scale),
	.energy(ch_out[31:0]),
	.speed({engine_config[`ETVB_CFG_PULSE_FAST],
		engine_config[`ETVB_CFG_PULSE_SLOW]}),
	.pulse(REAL_PULSE),
	.negative(REAL_NEGATIVE)
);

etvb_pulse u_reactive_pulse
(
	.clk(CLK),
	.nrst(NRST),
	.step(SAMPLE_STROBE),
	.rate(pulse_rate_scale),
	.energy(ch_out[95:64]),
	.speed({engine_config[`ETVB_CFG_PULSE_FAST],
		engine_config[`ETVB_CFG_PULSE_SLOW]}),
	.pulse(REACTIVE_PULSE),
	.negative(REACTIVE_NEGATIVE)
);

endmodule // etvb_top

`default_nettype wire

//--- sim/etvb_top_sva.sv
// checker for the transfer variable bank top ports
`timescale 1ns/100ps
`default_nettype none
module etvb_top_sva
#(
	parameter ACC_COUNT = 2520
)
(
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// samples and register port
	input wire logic SAMPLE_STROBE,
	input wire logic [11:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	// events and pulses
	input wire logic RESULT_READY_INT,
	input wire logic REAL_PULSE,
	input wire logic REAL_NEGATIVE,
	input wire logic REACTIVE_PULSE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic [31:0] cnt;
	logic hit;
	// strobes counted from reset, hit marks the cycle after the last strobe of an interval
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			cnt <= 32'h00000000;
			hit <= 1'b0;
		end
		else
		begin
			hit <= SAMPLE_STROBE && cnt == ACC_COUNT - 1;
			if (SAMPLE_STROBE)
				cnt <= (cnt == ACC_COUNT - 1) ? 32'h00000000 : cnt + 1;
		end
	end
	chk_int_interval: assert property (RESULT_READY_INT == hit)
		else $error("result event off the interval end");
	chk_int_single: assert property (RESULT_READY_INT |=> !RESULT_READY_INT)
		else $error("result event longer than one cycle");
	chk_rdata_hold: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property ($past(REG_RD) &&
		$past(REG_ADDR) == 12'h0FF |-> REG_RDATA == 32'h00000000)
		else $error("unmapped read not zero");
	chk_pulse_single: assert property (REAL_PULSE && !SAMPLE_STROBE
		|=> !REAL_PULSE)
		else $error("real pulse longer than one cycle");
	chk_pulse_cause: assert property (REAL_PULSE |-> $past(SAMPLE_STROBE))
		else $error("real pulse without a sample");
	chk_react_cause: assert property (REACTIVE_PULSE |-> $past(SAMPLE_STROBE))
		else $error("reactive pulse without a sample");
	chk_sign_hold: assert property (!$past(SAMPLE_STROBE) |-> $stable(REAL_NEGATIVE))
		else $error("real sign moved without a sample");
	cover property (RESULT_READY_INT);
	cover property (REAL_PULSE);
	cover property (REACTIVE_PULSE);
endmodule // etvb_top_sva
`default_nettype wire

//--- sim/etvb_host.sv
// host model: register port master of the bank
`timescale 1ns/100ps
`default_nettype none
module etvb_host
(
	// clock
	input wire logic clk,
	// register port
	output logic [11:0] addr,
	output logic wr,
	output logic rd,
	output logic [31:0] wdata,
	input wire logic [31:0] rdata
);
	initial
	begin
		addr = 12'h000;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 32'h00000000;
	end
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
	begin
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		wdata = ~d;
	end
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
	begin
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		d = rdata;
	end
	endtask
endmodule // etvb_host
`default_nettype wire

//--- sim/tb_top.sv
// testbench for the transfer variable bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk, nrst, stb, wr, rd, rint, rp, rn, qp, qn;
	logic [31:0] w0, w1, v0r, v1r, wdata, rdata, q;
	logic [15:0] i0, vv;
	logic [2:0] equ;
	logic [11:0] addr;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	int np = 0;
	int nq = 0;
	int ni = 0;
	etvb_top #(.ACC_COUNT(4)) i_dut (.CLK(clk), .NRST(nrst),
		.SAMPLE_STROBE(stb), .SAMPLE_W0(w0), .SAMPLE_W1(w1),
		.SAMPLE_VAR0(v0r), .SAMPLE_VAR1(v1r), .SAMPLE_I0(i0), .SAMPLE_I1(i0),
		.SAMPLE_V0(vv), .SAMPLE_V1(vv), .METER_EQU(equ), .REG_ADDR(addr),
		.REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
		.RESULT_READY_INT(rint), .REAL_PULSE(rp), .REAL_NEGATIVE(rn),
		.REACTIVE_PULSE(qp), .REACTIVE_NEGATIVE(qn));
	etvb_host i_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
		.wdata(wdata), .rdata(rdata));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		np += rp;
		nq += qp;
		ni += rint;
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	begin
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
	begin
		i_host.rd_reg(a, q);
		chk($sformatf("reg %h", a), e, q);
	end
	endtask
	// one sample of every channel, current and voltage shared by both elements
	task automatic smp(input logic [31:0] a, b, c, d, input logic [15:0] v);
	begin
		@(posedge clk);
		#1;
		{w0, w1, v0r, v1r, vv, stb} = {a, b, c, d, v, 1'b1};
		@(posedge clk);
		#1;
		stb = 1'b0;
	end
	endtask
	task automatic t_regs();
	begin
		rdchk(12'h020, 32'h00000000);
		rdchk(12'h021, 32'h00000100);
		rdchk(12'h085, 32'h00000000);
		i_host.wr_reg(12'h021, 32'h00000400);
		i_host.wr_reg(12'h085, 32'h00001234);
		rdchk(12'h021, 32'h00000400);
		rdchk(12'h085, 32'h00000000);
		rdchk(12'h0FF, 32'h00000000);
	end
	endtask
	task automatic t_interval();
	begin
		repeat (4) smp(32'hA, 32'h14, 32'hFFFFFFFB, 32'h7, 16'hFF9C);
		@(posedge clk);
		#1;
		chk("result events", 1, ni);
		rdchk(12'h085, 32'h00000028);
		rdchk(12'h086, 32'h00000050);
		rdchk(12'h084, 32'h00000078);
		rdchk(12'h088, 32'h00000008);
		rdchk(12'h089, 32'hFFFFFFEC);
		rdchk(12'h08C, 32'h00000024);
		rdchk(12'h090, 32'h00009C40);
		repeat (2) smp(32'h1, 32'h0, 32'h0, 32'h0, 16'h0064);
		rdchk(12'h085, 32'h00000028);
		repeat (2) smp(32'h1, 32'h0, 32'h0, 32'h0, 16'h0064);
		rdchk(12'h085, 32'h00000004);
		rdchk(12'h083, 32'h00000001);
	end
	endtask
	task automatic t_saturate();
	begin
		equ = 3'h0;
		repeat (4) smp(32'h7FFFFFFF, 32'h80000000, 32'h80000000, 0, 16'h64);
		rdchk(12'h085, 32'h7FFFFFFF);
		rdchk(12'h086, 32'h80000000);
		rdchk(12'h084, 32'h7FFFFFFF);
	end
	endtask
	// count pulses over 32 samples with the saturated results held
	task automatic run_pulses(input logic [31:0] cfg, rate);
	begin
		i_host.wr_reg(12'h020, cfg);
		i_host.wr_reg(12'h021, rate);
		np = 0;
		nq = 0;
		repeat (32) smp(32'h7FFFFFFF, 0, 32'h80000000, 0, 16'h64);
		@(posedge clk);
		#1;
	end
	endtask
	task automatic t_pulse();
	begin
		run_pulses(32'h2, 32'h400);
		chk("fast real pulses", 1, np >= 15 && np <= 17);
		chk("fast reactive pulses", 1, nq >= 15 && nq <= 17);
		chk("real sign", 0, rn);
		chk("reactive sign", 1, qn);
		run_pulses(32'h0, 32'h400);
		chk("base real pulses", 1, np <= 2);
		run_pulses(32'h2, 32'h0);
		chk("zero rate pulses", 0, np);
		run_pulses(32'h1, 32'h8000);
		chk("slow real pulses", 1, np >= 1 && np <= 3);
	end
	endtask
	task automatic tally_and_finish();
	begin
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	initial
	begin
		{nrst, stb, w0, w1, v0r, v1r} = 0;
		i0 = 16'h0003;
		vv = 16'h0000;
		equ = 3'h2;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		t_regs();
		t_interval();
		t_saturate();
		t_pulse();
		tally_and_finish();
	end
endmodule // tb_top
bind etvb_top etvb_top_sva #(.ACC_COUNT(ACC_COUNT)) i_sva (.CLK(CLK),
	.NRST(NRST), .SAMPLE_STROBE(SAMPLE_STROBE), .REG_ADDR(REG_ADDR),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.RESULT_READY_INT(RESULT_READY_INT), .REAL_PULSE(REAL_PULSE),
	.REAL_NEGATIVE(REAL_NEGATIVE), .REACTIVE_PULSE(REACTIVE_PULSE));
`default_nettype wire
